// File: thc_pkg.sv
// package: constants, register layout and types of the two-hand control monitor
package thc_pkg;
    // clock and logic execution cycle
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned EXEC_TIME_US = 1000;
    localparam int unsigned EXEC_CLKS    = CLK_HZ / 1_000_000 * EXEC_TIME_US;
    // configured times: 10 ms steps, 500 ms ceiling
    localparam int unsigned STEP_MS    = 10;
    localparam int unsigned STEP_TICKS = STEP_MS * 1000 / EXEC_TIME_US;
    localparam int unsigned MAX_MS     = 500;
    localparam int unsigned TW         = 10;
    localparam logic [TW-1:0] MAX_TICKS = TW'(MAX_MS * 1000 / EXEC_TIME_US);
    localparam logic [5:0]    MAX_UNITS = 6'(MAX_MS / STEP_MS);

    // register map, byte addresses
    localparam int unsigned AW = 5;
    localparam logic [AW-1:0] REG_CTRL     = 5'h00;
    localparam logic [AW-1:0] REG_DISC1    = 5'h04;
    localparam logic [AW-1:0] REG_DISC2    = 5'h08;
    localparam logic [AW-1:0] REG_SYNC     = 5'h0c;
    localparam logic [AW-1:0] REG_STATUS   = 5'h10;
    localparam logic [AW-1:0] REG_IRQ_STAT = 5'h14;
    localparam logic [AW-1:0] REG_IRQ_MASK = 5'h18;

    // control register layout, bit 4 downward
    typedef struct packed {
        logic       legacy;
        logic       use_fault;
        logic [1:0] nout;
        logic       two_pair;
    } thc_cfg_t;
    localparam thc_cfg_t   CFG_RST   = '{legacy: 1'b0, use_fault: 1'b0, nout: 2'h1,
                                         two_pair: 1'b0};
    localparam logic [1:0] NOUT_ERR1 = 2'h2;
    localparam logic [1:0] NOUT_ERR2 = 2'h3;
    localparam logic [5:0] TIME_RST  = MAX_UNITS;

    typedef enum logic [1:0] {
        ST_DIS  = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b11,
        ST_LOCK = 2'b10
    } thc_sync_st_t;

    typedef struct packed {
        logic [1:0] sync;
        logic       fault;
        logic       err2;
        logic       err1;
        logic       enable;
    } thc_status_t;

    typedef struct packed {
        logic sync_to;
        logic disc2;
        logic disc1;
        logic en_fall;
        logic en_rise;
    } thc_irq_t;

    typedef struct packed {
        logic active;
        logic off;
        logic err_a;
        logic err_b;
        logic evt;
    } thc_pair_t;

    // steps to execution cycles; zero is unlimited or the ceiling
    function automatic logic [TW-1:0] thc_ticks(input logic [5:0] u, input logic zero_unlim);
        logic [5:0] c;
        c = (u > MAX_UNITS) ? MAX_UNITS : u;
        if (c == 6'h00) begin
            c = zero_unlim ? 6'h00 : MAX_UNITS;
        end
        return TW'(c) * TW'(STEP_TICKS);
    endfunction
endpackage

// File: thc_pair.sv
// one dual-channel input pair with discrepancy timer
`timescale 1ns/1ps
`default_nettype none
module thc_pair (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // evaluation
    input  wire logic                    tick,
    input  wire logic                    in_a,
    input  wire logic                    in_b,
    input  wire logic                    cmpl,
    input  wire logic [thc_pkg::TW-1:0]  limit,
    output var  thc_pkg::thc_pair_t      st
);
    logic                   armed_q;
    logic                   expired_q;
    logic                   last_on_q;
    logic                   active_q;
    logic                   err_a_q;
    logic                   err_b_q;
    logic                   evt_q;
    logic [thc_pkg::TW-1:0] cnt_q;

    wire b_on     = cmpl ? ~in_b : in_b;
    wire both_on  = in_a & b_on;
    wire both_off = ~in_a & ~b_on;
    wire timeout  = (limit != '0) && !expired_q && (cnt_q + 1'b1 >= limit);

    assign st = '{active: active_q, off: both_off, err_a: err_a_q, err_b: err_b_q,
                  evt: evt_q};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            armed_q   <= 1'b0;
            expired_q <= 1'b0;
            last_on_q <= 1'b0;
            active_q  <= 1'b0;
            err_a_q   <= 1'b0;
            err_b_q   <= 1'b0;
            evt_q     <= 1'b0;
            cnt_q     <= '0;
        end else begin
            evt_q <= 1'b0;
            if (tick) begin
                if (both_off) begin
                    armed_q   <= 1'b1;
                    expired_q <= 1'b0;
                    last_on_q <= 1'b0;
                    active_q  <= 1'b0;
                    cnt_q     <= '0;
                end else if (both_on) begin
                    cnt_q     <= '0;
                    last_on_q <= 1'b1;
                    // release only after both went off, within the time
                    if (armed_q && !expired_q) begin
                        active_q <= 1'b1;
                        armed_q  <= 1'b0;
                        err_a_q  <= 1'b0;
                        err_b_q  <= 1'b0;
                    end
                end else begin
                    active_q <= 1'b0;
                    if (timeout) begin
                        // blame the input still in the old state
                        expired_q <= 1'b1;
                        evt_q     <= 1'b1;
                        err_a_q   <= err_a_q | (in_a == last_on_q);
                        err_b_q   <= err_b_q | (b_on == last_on_q);
                    end else if (limit != '0 && !expired_q) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_PAIR_ON: assert property ($rose(active_q) |-> $past(tick && both_on))
        else $error("pair released without both channels on");
    AST_PAIR_ERR: assert property ($rose(err_a_q) |-> $past(tick && !both_on && !both_off))
        else $error("discrepancy error outside a discrepant sample");
    AST_PAIR_UNLIM: assert property ((limit == '0) && !expired_q |=> !expired_q)
        else $error("unlimited discrepancy time expired");
endmodule // thc_pair
`default_nettype wire

// File: thc_monitor.sv
// two-hand control monitor top: input sampling, pairs, synchronization, avalon registers
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - one pair: equivalent inputs both on release
// - one-pair discrepancy 10..500 ms, legacy 500
// - one pair: enable, optionally discrepancy error
// - two pairs, each valid only complementary
// - per-pair discrepancy, 0 unlimited, else 10..500
// - sync time 10..500 ms, 0 or legacy 500
// - sync window never exceeds 500 ms
// - disabled state only when both pairs off
// - sync timeout is not an error
// - sync timeout keeps enable low this attempt
// - two pairs: one, two or three outputs
// - timer starts on change, flags lagging input
module thc_monitor #(
    parameter int unsigned EXEC_CLKS = thc_pkg::EXEC_CLKS
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // avalon-mm slave
    input  wire logic [thc_pkg::AW-1:0]  avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    input  wire logic [3:0]              avs_byteenable,
    output var  logic [31:0]             avs_readdata,
    output var  logic                    avs_waitrequest,
    // hand switch contacts
    input  wire logic                    hand_1a,
    input  wire logic                    hand_1b,
    input  wire logic                    hand_2a,
    input  wire logic                    hand_2b,
    // safety outputs
    output var  logic                    release_en,
    output var  logic                    disc_err1,
    output var  logic                    disc_err2,
    output var  logic                    fault_present,
    output var  logic                    irq
);
    localparam int unsigned CW = $clog2(EXEC_CLKS);

    // registers
    thc_pkg::thc_cfg_t      cfg_q;
    logic [5:0]             disc_u_q [2];
    logic [5:0]             sync_u_q;
    thc_pkg::thc_irq_t      irq_stat_q;
    thc_pkg::thc_irq_t      irq_mask_q;
    // input sampling and execution cycle
    logic [3:0]             s1_q;
    logic [3:0]             s2_q;
    logic [3:0]             s3_q;
    logic [3:0]             in_f_q;
    logic [CW-1:0]          exec_cnt_q;
    logic                   tick_q;
    // synchronization
    thc_pkg::thc_sync_st_t  st_q;
    thc_pkg::thc_sync_st_t  st_d;
    logic [thc_pkg::TW-1:0] scnt_q;
    logic [thc_pkg::TW-1:0] scnt_d;
    logic                   sync_evt_q;
    logic                   sync_evt_d;
    thc_pkg::thc_pair_t     pst [2];
    logic [thc_pkg::TW-1:0] lim [2];

    // pairs: 1a/1b, 2a/2b
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pair
            thc_pair thc_pair_inst (
                .clk_sys (clk_sys),
                .rst_n   (rst_n),
                .tick    (tick_q),
                .in_a    (in_f_q[2*i]),
                .in_b    (in_f_q[2*i+1]),
                .cmpl    ((i == 0) ? cfg_q.two_pair : 1'b1),
                .limit   (lim[i]),
                .st      (pst[i])
            );
        end
    endgenerate

    // one pair never unlimited; legacy firmware pins the time
    wire fixed_disc = cfg_q.legacy && !cfg_q.two_pair;
    assign lim[0] = fixed_disc ? thc_pkg::MAX_TICKS
                               : thc_pkg::thc_ticks(disc_u_q[0], cfg_q.two_pair);
    assign lim[1] = thc_pkg::thc_ticks(disc_u_q[1], 1'b1);
    // zero and anything above the ceiling give 500 ms
    wire [thc_pkg::TW-1:0] sync_lim = cfg_q.legacy ? thc_pkg::MAX_TICKS
                                                   : thc_pkg::thc_ticks(sync_u_q, 1'b0);

    wire both_dis = pst[0].off && pst[1].off;
    wire both_act = pst[0].active && pst[1].active;
    wire err1_any = pst[0].err_a | pst[0].err_b;
    wire err2_any = (pst[1].err_a | pst[1].err_b) & cfg_q.two_pair;
    wire en_raw   = cfg_q.two_pair ? (st_q == thc_pkg::ST_RUN) : pst[0].active;

    // synchronization between the two pairs, stepped once per execution cycle
    always_comb begin
        st_d       = st_q;
        scnt_d     = scnt_q;
        sync_evt_d = 1'b0;
        if (!cfg_q.two_pair) begin
            st_d   = thc_pkg::ST_DIS;
            scnt_d = '0;
        end else if (tick_q) begin
            case (st_q)
                thc_pkg::ST_DIS: begin
                    scnt_d = '0;
                    if (both_act) begin
                        st_d = thc_pkg::ST_RUN;
                    end else if (!both_dis) begin
                        st_d = thc_pkg::ST_WAIT;
                    end
                end
                thc_pkg::ST_WAIT: begin
                    if (both_dis) begin
                        st_d = thc_pkg::ST_DIS;
                    end else if (both_act) begin
                        st_d = thc_pkg::ST_RUN;
                    end else if (scnt_q + 1'b1 >= sync_lim) begin
                        // no error output, only an event for software
                        st_d       = thc_pkg::ST_LOCK;
                        sync_evt_d = 1'b1;
                    end else begin
                        scnt_d = scnt_q + 1'b1;
                    end
                end
                thc_pkg::ST_RUN: begin
                    if (both_dis) begin
                        st_d = thc_pkg::ST_DIS;
                    end else if (!both_act) begin
                        st_d = thc_pkg::ST_LOCK; // one hand let go: full release needed
                    end
                end
                thc_pkg::ST_LOCK: begin
                    if (both_dis) begin
                        st_d = thc_pkg::ST_DIS;
                    end
                end
                default: st_d = thc_pkg::ST_DIS;
            endcase
        end
    end

    // three flops, a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q   <= 4'h0;
            s2_q   <= 4'h0;
            s3_q   <= 4'h0;
            in_f_q <= 4'h0;
        end else begin
            s1_q <= {hand_2b, hand_2a, hand_1b, hand_1a};
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_f_q <= (s2_q == s3_q) ? s3_q : in_f_q;
        end
    end

    // execution cycle strobe; all timers count these
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            exec_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (exec_cnt_q == CW'(EXEC_CLKS - 1));
            exec_cnt_q <= (exec_cnt_q == CW'(EXEC_CLKS - 1)) ? '0 : exec_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q       <= thc_pkg::ST_DIS;
            scnt_q     <= '0;
            sync_evt_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            scnt_q     <= scnt_d;
            sync_evt_q <= sync_evt_d;
        end
    end

    // outputs selected by the configured output count; fault_present by use_fault
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            release_en    <= 1'b0;
            disc_err1     <= 1'b0;
            disc_err2     <= 1'b0;
            fault_present <= 1'b0;
        end else begin
            release_en    <= en_raw;
            disc_err1     <= err1_any && (cfg_q.nout >= thc_pkg::NOUT_ERR1);
            disc_err2     <= err2_any && (cfg_q.nout == thc_pkg::NOUT_ERR2);
            fault_present <= cfg_q.use_fault && (err1_any || err2_any);
        end
    end

    // bus: one wait state, the request is taken when waitrequest is low
    wire bus_req = avs_read | avs_write;
    wire accept  = bus_req & avs_waitrequest;
    wire wr_en   = avs_write & ~avs_waitrequest & avs_byteenable[0];

    function automatic logic hit(input logic [thc_pkg::AW-1:0] a);
        return wr_en && (avs_address == a);
    endfunction

    thc_pkg::thc_status_t status;
    assign status = '{sync: st_q, fault: fault_present, err2: disc_err2, err1: disc_err1,
                      enable: release_en};

    thc_pkg::thc_irq_t evt;
    assign evt = '{sync_to: sync_evt_q, disc2: pst[1].evt && cfg_q.two_pair,
                   disc1: pst[0].evt, en_fall: release_en && !en_raw,
                   en_rise: !release_en && en_raw};

    // plain decode: a function reading module nets never wakes a continuous assignment
    wire stat_wr = wr_en && (avs_address == thc_pkg::REG_IRQ_STAT);
    thc_pkg::thc_irq_t w1c;
    assign w1c = stat_wr ? thc_pkg::thc_irq_t'(avs_writedata[4:0]) : '0;

    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            thc_pkg::REG_CTRL:     rd_mux = 32'(cfg_q);
            thc_pkg::REG_DISC1:    rd_mux = 32'(disc_u_q[0]);
            thc_pkg::REG_DISC2:    rd_mux = 32'(disc_u_q[1]);
            thc_pkg::REG_SYNC:     rd_mux = 32'(sync_u_q);
            thc_pkg::REG_STATUS:   rd_mux = 32'(status);
            thc_pkg::REG_IRQ_STAT: rd_mux = 32'(irq_stat_q);
            thc_pkg::REG_IRQ_MASK: rd_mux = 32'(irq_mask_q);
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~accept;
            if (accept) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // a change of configuration gates the outputs from the next clock; pairs act on it at the next execution cycle, sync too unless two_pair is cleared (next clock)
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_q       <= thc_pkg::CFG_RST;
            disc_u_q[0] <= thc_pkg::TIME_RST;
            disc_u_q[1] <= thc_pkg::TIME_RST;
            sync_u_q    <= thc_pkg::TIME_RST;
            irq_mask_q  <= '0;
        end else begin
            if (hit(thc_pkg::REG_CTRL))     cfg_q       <= thc_pkg::thc_cfg_t'(avs_writedata[4:0]);
            if (hit(thc_pkg::REG_DISC1))    disc_u_q[0] <= avs_writedata[5:0];
            if (hit(thc_pkg::REG_DISC2))    disc_u_q[1] <= avs_writedata[5:0];
            if (hit(thc_pkg::REG_SYNC))     sync_u_q    <= avs_writedata[5:0];
            if (hit(thc_pkg::REG_IRQ_MASK)) irq_mask_q  <= thc_pkg::thc_irq_t'(avs_writedata[4:0]);
        end
    end

    // new events win over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~w1c) | evt;
            irq        <= |(irq_stat_q & irq_mask_q);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_ONE_PAIR_EN: assert property ($rose(release_en) && !cfg_q.two_pair |->
        $past(in_f_q[0] && in_f_q[1], 2)) else $error("release without both inputs on");
    AST_DISC_RANGE: assert property (!cfg_q.two_pair |-> lim[0] >= thc_pkg::STEP_TICKS &&
        lim[0] <= thc_pkg::MAX_TICKS) else $error("single pair time out of range");
    AST_ONE_OUT: assert property (!cfg_q.two_pair && cfg_q.nout < thc_pkg::NOUT_ERR1 |=>
        !disc_err1 && !disc_err2) else $error("error output with one output");
    AST_SYNC_RANGE: assert property (sync_lim >= thc_pkg::STEP_TICKS &&
        sync_lim <= thc_pkg::MAX_TICKS) else $error("sync time out of range");
    AST_SYNC_MAX: assert property (scnt_q < thc_pkg::MAX_TICKS)
        else $error("sync window beyond ceiling");
    AST_DIS_ENTRY: assert property (st_q != thc_pkg::ST_DIS && st_d == thc_pkg::ST_DIS &&
        cfg_q.two_pair |-> both_dis) else $error("disabled state with a pair still on");
    AST_NO_SYNC_ERR: assert property (fault_present |-> $past(err1_any || err2_any))
        else $error("fault without a discrepancy error");
    AST_LOCK_LOW: assert property (st_q == thc_pkg::ST_LOCK |=> !release_en)
        else $error("release after sync timeout");
    AST_TWO_OUT: assert property (cfg_q.nout != thc_pkg::NOUT_ERR2 |=> !disc_err2)
        else $error("pair two error without three outputs");
    AST_TICK_GAP: assert property (tick_q |=> !tick_q)
        else $error("execution strobe twice in a row");
    AST_BUS_ONE: assert property (accept |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    COV_RUN: cover property (st_q == thc_pkg::ST_WAIT ##1 st_q == thc_pkg::ST_RUN);
    COV_LOCK: cover property (sync_evt_q);
    COV_DISC: cover property ($rose(disc_err1));
    COV_IRQ: cover property ($rose(irq));
endmodule // thc_monitor
`default_nettype wire

// File: thc_hand_model.sv
// two-hand push-button switch pair model with a lagging second contact
`timescale 1ns/1ps
`default_nettype none
module thc_hand_model #(
    parameter int unsigned LAG = 0
) (
    // clock
    input  wire logic clk_sys,
    // wiring and operator
    input  wire logic two_pair,
    input  wire logic push_1,
    input  wire logic push_2,
    input  wire logic stuck_1,
    input  wire logic stuck_2,
    // contacts
    output var  logic hand_1a,
    output var  logic hand_1b,
    output var  logic hand_2a,
    output var  logic hand_2b
);
    logic [7:0] dly1_q;
    logic [7:0] dly2_q;
    wire        b1_on = dly1_q[LAG] & ~stuck_1;
    wire        b2_on = dly2_q[LAG] & ~stuck_2;

    // second contact closes late, as worn mechanics do
    always_ff @(posedge clk_sys) begin
        dly1_q <= {dly1_q[6:0], push_1};
        dly2_q <= {dly2_q[6:0], push_2};
    end

    // complementary wiring with two pairs, equivalent with one
    assign hand_1a = push_1;
    assign hand_1b = two_pair ? ~b1_on : b1_on;
    assign hand_2a = push_2;
    assign hand_2b = two_pair ? ~b2_on : b2_on;
endmodule // thc_hand_model
`default_nettype wire

// File: thc_monitor_tb_top.sv
// self-checking bench of the two-hand control monitor
`timescale 1ns/1ps
`default_nettype none
module thc_monitor_tb_top;
    logic        clk_sys;
    logic        rst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        hand_1a, hand_1b, hand_2a, hand_2b;
    logic        release_en, disc_err1, disc_err2, fault_present, irq;
    logic        two_pair, push_1, push_2, stuck_1, stuck_2;
    logic [31:0] rd;
    int          failures;
    int          n_compared;

    // short execution cycle: one tick every 8 clocks
    thc_monitor #(.EXEC_CLKS(8)) thc_monitor_inst (.clk_sys, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .hand_1a, .hand_1b, .hand_2a, .hand_2b, .release_en, .disc_err1, .disc_err2,
        .fault_present, .irq);
    thc_hand_model #(.LAG(5)) thc_hand_model_inst (.clk_sys, .two_pair, .push_1, .push_2,
        .stuck_1, .stuck_2, .hand_1a, .hand_1b, .hand_2a, .hand_2b);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // request held until waitrequest is sampled low; the watchdog cuts a hang
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_en(input int lim);
        for (int i = 0; i < lim && release_en !== 1'b1; i++) @(posedge clk_sys);
    endtask
    task automatic idle;
        push_1  <= 1'b0;
        push_2  <= 1'b0;
        stuck_1 <= 1'b0;
        stuck_2 <= 1'b0;
        cyc(60);
    endtask

    task automatic t_reset;
        bus(1'b0, thc_pkg::REG_CTRL, '0);
        chk_word("ctrl", 32'h02, rd);
        bus(1'b0, thc_pkg::REG_DISC1, '0);
        chk_word("disc1", 32'h32, rd);
        bus(1'b0, thc_pkg::REG_SYNC, '0);
        chk_word("sync", 32'h32, rd);
        bus(1'b0, 5'h1c, '0);
        chk_word("unmapped", 32'h0, rd);
        chk_bit("enable", 1'b0, release_en);
        $display("test reset done");
    endtask

    task automatic t_single;
        bus(1'b1, thc_pkg::REG_IRQ_MASK, 32'h01);
        bus(1'b1, thc_pkg::REG_IRQ_STAT, 32'h1f);
        push_1 <= 1'b1;
        wait_en(200);
        chk_bit("enable", 1'b1, release_en);
        cyc(3);
        chk_bit("irq", 1'b1, irq);
        bus(1'b1, thc_pkg::REG_IRQ_STAT, 32'h01);
        cyc(2);
        chk_bit("irq cleared", 1'b0, irq);
        idle();
        chk_bit("enable off", 1'b0, release_en);
        // one unit is 10 ticks, 80 clocks; half of it must pass quietly
        bus(1'b1, thc_pkg::REG_CTRL, 32'h0c);
        bus(1'b1, thc_pkg::REG_DISC1, 32'h01);
        stuck_1 <= 1'b1;
        push_1  <= 1'b1;
        cyc(40);
        chk_bit("err early", 1'b0, disc_err1);
        cyc(160);
        chk_bit("err1", 1'b1, disc_err1);
        chk_bit("fault", 1'b1, fault_present);
        chk_bit("enable", 1'b0, release_en);
        bus(1'b0, thc_pkg::REG_IRQ_STAT, '0);
        chk_word("disc event", 32'h04, rd & 32'h04);
        idle();
        push_1 <= 1'b1;
        wait_en(200);
        chk_bit("enable", 1'b1, release_en);
        chk_bit("err1 cleared", 1'b0, disc_err1);
        idle();
        // legacy pins the time at 500 ms, so the one-unit setting must not trip
        bus(1'b1, thc_pkg::REG_CTRL, 32'h1c);
        stuck_1 <= 1'b1;
        push_1  <= 1'b1;
        cyc(200);
        chk_bit("err1 legacy", 1'b0, disc_err1);
        idle();
        $display("test single pair done");
    endtask

    task automatic t_two;
        two_pair <= 1'b1;
        bus(1'b1, thc_pkg::REG_CTRL, 32'h0f);
        bus(1'b1, thc_pkg::REG_DISC1, 32'h00);
        bus(1'b1, thc_pkg::REG_DISC2, 32'h01);
        bus(1'b1, thc_pkg::REG_SYNC, 32'h01);
        idle();
        push_1 <= 1'b1;
        push_2 <= 1'b1;
        wait_en(300);
        chk_bit("enable", 1'b1, release_en);
        bus(1'b0, thc_pkg::REG_STATUS, '0);
        chk_word("status run", 32'h31, rd);
        idle();
        // second hand far beyond the 10-tick window
        bus(1'b1, thc_pkg::REG_IRQ_STAT, 32'h1f);
        push_1 <= 1'b1;
        cyc(300);
        push_2 <= 1'b1;
        cyc(200);
        chk_bit("late enable", 1'b0, release_en);
        chk_bit("no err1", 1'b0, disc_err1);
        chk_bit("no err2", 1'b0, disc_err2);
        chk_bit("no fault", 1'b0, fault_present);
        bus(1'b0, thc_pkg::REG_IRQ_STAT, '0);
        chk_word("sync event", 32'h10, rd & 32'h10);
        // only one pair let go: no disabled state, still locked
        push_1 <= 1'b0;
        cyc(60);
        push_1 <= 1'b1;
        cyc(200);
        chk_bit("one pair off", 1'b0, release_en);
        idle();
        push_1 <= 1'b1;
        push_2 <= 1'b1;
        wait_en(300);
        chk_bit("both off", 1'b1, release_en);
        idle();
        // pair 1 unlimited, pair 2 one unit
        stuck_1 <= 1'b1;
        stuck_2 <= 1'b1;
        push_1  <= 1'b1;
        push_2  <= 1'b1;
        cyc(300);
        chk_bit("err1 unlimited", 1'b0, disc_err1);
        chk_bit("err2", 1'b1, disc_err2);
        chk_bit("fault", 1'b1, fault_present);
        chk_bit("enable", 1'b0, release_en);
        idle();
        $display("test two pairs done");
    endtask

    task automatic finish_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the tests take about 2300 clocks
    initial begin
        cyc(30000);
        failures++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        {two_pair, push_1, push_2, stuck_1, stuck_2} = '0;
        failures = 0;
        n_compared = 0;
        cyc(20);
        rst_n <= 1'b1;
        cyc(60);
        t_reset();
        t_single();
        t_two();
        finish_test();
    end
endmodule // thc_monitor_tb_top
`default_nettype wire
